/* core/spd_regs.svh */
// Purpose: Constants for the serial PLL divider control ends
// Assumes: pclk at 50 MHz; serial link sampled in the pclk domain
// Notes: Word layouts are LSB = latch select bit
`ifndef SPD_REGS_SVH
`define SPD_REGS_SVH
`define SPD_REF_WORD_BITS 16
`define SPD_DIV_WORD_BITS 20
`define SPD_SHIFT_BITS 20
`define SPD_REF_CNT_BITS 14
`define SPD_MAIN_BITS 11
`define SPD_SWAL_BITS 8
`define SPD_SEL_POS 0
`define SPD_REF_CNT_LSB 1
`define SPD_REF_RATIO_POS 15
`define SPD_SWAL_LSB 1
`define SPD_MAIN_LSB 9
`define SPD_MOD_SMALL 9'h080
`define SPD_MOD_LARGE 9'h100
`define SPD_REF_RST 14'h0008
`define SPD_MAIN_RST 11'h010
`define SPD_SWAL_RST 8'h00
`define SPD_SPIKE_CYCLES 2
`define SPD_HOST_HALF 4
`define SPD_REG_CTRL 12'h000
`define SPD_REG_REFW 12'h004
`define SPD_REG_DIVW 12'h008
`define SPD_REG_STAT 12'h00C
`endif

/* core/spd_pkg.sv */
// Purpose: Types for the two ends: host states used by the host, comparator result by the synthesizer
// Assumes: Constants come from spd_regs.svh
// Notes: Host states one-hot
package spd_pkg;
   typedef enum logic [3:0] {
      SPD_IDLE = 4'b0001,
      SPD_SHIFT = 4'b0010,
      SPD_LOAD = 4'b0100,
      SPD_DONE = 4'b1000
   } spd_host_state_t;
   typedef enum logic [1:0] {
      SPD_CMP_EQ = 2'b00,
      SPD_CMP_REF_LEADS = 2'b01,
      SPD_CMP_VCO_LEADS = 2'b10
   } spd_cmp_t;
endpackage

/* core/spd_link_if.sv */
// Purpose: Three-wire link plus polarity pin between host and synthesizer
// Assumes: Host drives data, shift clock, strobe, polarity
// Notes: No default values on the pins; host reset drives strobe low and polarity high
`timescale 1ns/10ps
`default_nettype none
interface spd_link_if;
   logic serial_data;
   logic shift_clk;
   logic latch_load_strobe;
   logic phase_polarity_select;
   modport host (
      output serial_data,
      output shift_clk,
      output latch_load_strobe,
      output phase_polarity_select
   );
   modport device (
      input serial_data,
      input shift_clk,
      input latch_load_strobe,
      input phase_polarity_select
   );
endinterface
`default_nettype wire

/* core/spd_synth.sv */
// Purpose: Synthesizer end: serial load, dividers, comparator, pump drives
// Assumes: All pins sampled in pclk; ref and VCO inputs slower than pclk/4
// Notes: Three-state outputs come as value plus enable
//
// Added by the designer: the address map and the APB register port.
`timescale 1ns/10ps
`default_nettype none
`include "spd_regs.svh"
module spd_synth #(
   parameter int SPIKE_CYCLES = `SPD_SPIKE_CYCLES
) (
   // Clock, reset, enable
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clk_en,
   // Serial link
   spd_link_if.device link,
   // Oscillator and VCO inputs
   input wire logic ref_osc_input,
   input wire logic vco_input,
   // Charge pump and drives
   output logic pump_out,
   output logic pump_oe,
   output logic r_drive,
   output logic p_drive_out,
   output logic p_drive_oe,
   output logic fast_lock_switch_out,
   output logic fast_lock_switch_oe,
   output logic compare_monitor,
   output logic lock_indicator,
   // Latch view
   output logic [13:0] ref_count,
   output logic prescaler_ratio_select,
   output logic [10:0] main_count,
   output logic [7:0] swallow_count
);
   logic [4:0] s1_reg, s2_reg;
   logic sck_d_reg;
   logic [19:0] shift_reg;
   logic [13:0] ref_cnt_reg;
   logic [8:0] pre_cnt_reg;
   logic [10:0] main_cnt_reg;
   logic [7:0] swal_cnt_reg;
   logic ref_cmp_reg, vco_cmp_reg, ref_d_reg, vco_d_reg;
   logic [13:0] ref_latch_reg;
   logic ratio_latch_reg;
   logic [10:0] main_latch_reg;
   logic [7:0] swal_latch_reg;
   logic ref_lead_reg, vco_lead_reg;
   logic [3:0] spike_reg;
   logic ref_rise, vco_rise, sck_rise, le_high, pol;
   logic [8:0] modulus;
   logic pre_wrap, ref_wrap;
   spd_pkg::spd_cmp_t cmp;
   // Two-flop sync of pins: data, clock, strobe, polarity, ref, vco
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s1_reg <= 5'h0_0;
         s2_reg <= 5'h0_0;
      end else if (clk_en) begin
         s1_reg <= {link.serial_data, link.shift_clk, link.latch_load_strobe,
                    link.phase_polarity_select, vco_input};
         s2_reg <= s1_reg;
      end
   end
   logic ref_s1_reg, ref_s2_reg;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ref_s1_reg <= 1'b0;
         ref_s2_reg <= 1'b0;
      end else if (clk_en) begin
         ref_s1_reg <= ref_osc_input;
         ref_s2_reg <= ref_s1_reg;
      end
   end
   assign sck_rise = s2_reg[3] & ~sck_d_reg;
   assign le_high = s2_reg[2];
   assign pol = s2_reg[1];
   assign ref_rise = ref_s2_reg & ~ref_d_reg;
   assign vco_rise = s2_reg[0] & ~vco_d_reg;
   assign modulus = ratio_latch_reg ? `SPD_MOD_SMALL : `SPD_MOD_LARGE;
   assign pre_wrap = (swal_cnt_reg != 8'h00) ? (pre_cnt_reg == modulus) : (pre_cnt_reg == modulus - 9'h001);
   assign ref_wrap = (ref_cnt_reg >= ref_latch_reg - 14'h0001);
   // Shift register and edge history
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sck_d_reg <= 1'b0;
         ref_d_reg <= 1'b0;
         vco_d_reg <= 1'b0;
         shift_reg <= 20'h0_0000;
      end else if (clk_en) begin
         sck_d_reg <= s2_reg[3];
         ref_d_reg <= ref_s2_reg;
         vco_d_reg <= s2_reg[0];
         if (sck_rise) begin
            shift_reg <= {shift_reg[18:0], s2_reg[4]};
         end
      end
   end
   // Latches transfer while strobe is high; level-sensitive, so words keep loading
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ref_latch_reg <= `SPD_REF_RST;
         ratio_latch_reg <= 1'b1;
         main_latch_reg <= `SPD_MAIN_RST;
         swal_latch_reg <= `SPD_SWAL_RST;
      end else if (clk_en && le_high) begin
         if (shift_reg[`SPD_SEL_POS]) begin
            ref_latch_reg <= shift_reg[14:1];
            ratio_latch_reg <= shift_reg[`SPD_REF_RATIO_POS];
         end else begin
            swal_latch_reg <= shift_reg[8:1];
            main_latch_reg <= shift_reg[19:9];
         end
      end
   end
   // pulse-swallow VCO divider; ref divider relies on host range
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pre_cnt_reg <= 9'h000;
         main_cnt_reg <= 11'h000;
         swal_cnt_reg <= 8'h00;
         vco_cmp_reg <= 1'b0;
         ref_cnt_reg <= 14'h0000;
         ref_cmp_reg <= 1'b0;
      end else if (clk_en) begin
         vco_cmp_reg <= 1'b0;
         ref_cmp_reg <= 1'b0;
         if (vco_rise) begin
            if (pre_wrap) begin
               pre_cnt_reg <= 9'h000;
               if (swal_cnt_reg != 8'h00) begin
                  swal_cnt_reg <= swal_cnt_reg - 8'h01;
               end
               if (main_cnt_reg <= 11'h001) begin
                  main_cnt_reg <= main_latch_reg;
                  swal_cnt_reg <= swal_latch_reg;
                  vco_cmp_reg <= 1'b1;
               end else begin
                  main_cnt_reg <= main_cnt_reg - 11'h001;
               end
            end else begin
               pre_cnt_reg <= pre_cnt_reg + 9'h001;
            end
         end
         if (ref_rise) begin
            if (ref_wrap) begin
               ref_cnt_reg <= 14'h0000;
               ref_cmp_reg <= 1'b1;
            end else begin
               ref_cnt_reg <= ref_cnt_reg + 14'h0001;
            end
         end
         // new ratios act at once; an old large count would delay them
         if (le_high && shift_reg[`SPD_SEL_POS]) begin
            ref_cnt_reg <= 14'h0000;
         end
         if (le_high && !shift_reg[`SPD_SEL_POS]) begin
            pre_cnt_reg <= 9'h000;
            main_cnt_reg <= shift_reg[19:9];
            swal_cnt_reg <= shift_reg[8:1];
         end
      end
   end
   // tri-state phase/frequency detector with balance spike
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ref_lead_reg <= 1'b0;
         vco_lead_reg <= 1'b0;
         spike_reg <= 4'h0;
      end else if (clk_en) begin
         if (spike_reg != 4'h0) begin
            spike_reg <= spike_reg - 4'h1;
         end
         if ((ref_cmp_reg | ref_lead_reg) && (vco_cmp_reg | vco_lead_reg)) begin
            ref_lead_reg <= 1'b0;
            vco_lead_reg <= 1'b0;
            spike_reg <= 4'(SPIKE_CYCLES);
         end else begin
            ref_lead_reg <= ref_lead_reg | ref_cmp_reg;
            vco_lead_reg <= vco_lead_reg | vco_cmp_reg;
         end
      end
   end
   assign cmp = ref_lead_reg ? spd_pkg::SPD_CMP_REF_LEADS :
                vco_lead_reg ? spd_pkg::SPD_CMP_VCO_LEADS : spd_pkg::SPD_CMP_EQ;
   // drive tables, spike shows as brief ref-leads pulse
   logic up, dn;
   // Spike yields to a real VCO lead so the drives never fight
   assign up = (cmp == spd_pkg::SPD_CMP_REF_LEADS) || (spike_reg != 4'h0 && cmp != spd_pkg::SPD_CMP_VCO_LEADS);
   assign dn = (cmp == spd_pkg::SPD_CMP_VCO_LEADS);
   assign pump_oe = up | dn;
   assign pump_out = pol ? up : dn;
   assign r_drive = pol ? dn : up;
   // open drain P drive, value always low
   assign p_drive_out = 1'b0;
   assign p_drive_oe = pol ? up : dn;
   assign compare_monitor = pol ? ref_cmp_reg : vco_cmp_reg;
   assign lock_indicator = ~(ref_lead_reg | vco_lead_reg);
   assign fast_lock_switch_oe = le_high & pump_oe;
   assign fast_lock_switch_out = pump_out;
   assign ref_count = ref_latch_reg;
   assign prescaler_ratio_select = ratio_latch_reg;
   assign main_count = main_latch_reg;
   assign swallow_count = swal_latch_reg;
endmodule
`default_nettype wire

/* core/spd_host.sv */
// Purpose: Host end: APB slave that shifts words onto the three-wire link
// Assumes: Software writes a word then sets go; polls busy
// Notes: Link clock made by divider from pclk
`timescale 1ns/10ps
`default_nettype none
`include "spd_regs.svh"
module spd_host #(
   parameter int HALF = `SPD_HOST_HALF
) (
   // Clock, reset, enable
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clk_en,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Link
   spd_link_if.host link
);
   spd_pkg::spd_host_state_t state_reg;
   logic [19:0] word_reg, ref_word_reg, div_word_reg;
   logic [4:0] bits_reg;
   logic [7:0] half_reg;
   logic sck_reg, le_reg, pol_reg, sel_div_reg, done_reg, dat_reg;
   logic [31:0] prdata_reg;
   logic acc, wr, rd, setup_rd, mapped, half_done;
   assign acc = psel & penable & clk_en;
   assign setup_rd = psel & ~penable & ~pwrite & clk_en;
   assign wr = acc & pwrite;
   assign rd = acc & ~pwrite;
   assign mapped = (paddr == `SPD_REG_CTRL) || (paddr == `SPD_REG_REFW) ||
                   (paddr == `SPD_REG_DIVW) || (paddr == `SPD_REG_STAT);
   assign pready = 1'b1;
   assign pslverr = psel & penable & ~mapped;
   assign prdata = prdata_reg;
   assign half_done = (half_reg == 8'(HALF - 1));
   // Register writes and link sequencer
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg <= spd_pkg::SPD_IDLE;
         word_reg <= 20'h0_0000;
         ref_word_reg <= 20'h0_0001;
         div_word_reg <= 20'h0_0000;
         bits_reg <= 5'h0_0;
         half_reg <= 8'h00;
         sck_reg <= 1'b0;
         le_reg <= 1'b0;
         dat_reg <= 1'b0;
         pol_reg <= 1'b1;
         sel_div_reg <= 1'b0;
         done_reg <= 1'b0;
         prdata_reg <= 32'h0000_0000;
      end else if (clk_en) begin
         // Read data captured in setup so it stands at the pready edge
         if (setup_rd) begin
            prdata_reg <= (paddr == `SPD_REG_CTRL) ? {30'h0000_0000, sel_div_reg, pol_reg} :
                          (paddr == `SPD_REG_REFW) ? {12'h000, ref_word_reg} :
                          (paddr == `SPD_REG_DIVW) ? {12'h000, div_word_reg} :
                          (paddr == `SPD_REG_STAT) ?
                          {30'h0000_0000, done_reg, state_reg != spd_pkg::SPD_IDLE} : 32'h0000_0000;
         end
         if (wr && paddr == `SPD_REG_REFW) begin
            ref_word_reg <= pwdata[19:0];
         end
         if (wr && paddr == `SPD_REG_DIVW) begin
            div_word_reg <= pwdata[19:0];
         end
         if (wr && paddr == `SPD_REG_CTRL) begin
            pol_reg <= pwdata[0];
         end
         // Done is sticky; cleared only once a read has shown it
         if (rd && paddr == `SPD_REG_STAT && prdata_reg[1]) begin
            done_reg <= 1'b0;
         end
         half_reg <= half_done ? 8'h00 : half_reg + 8'h01;
         case (state_reg)
            spd_pkg::SPD_IDLE: begin
               half_reg <= 8'h00;
               // Go: bit 8 starts, bit 1 picks divider word
               if (wr && paddr == `SPD_REG_CTRL && pwdata[8]) begin
                  sel_div_reg <= pwdata[1];
                  word_reg <= pwdata[1] ? div_word_reg : {ref_word_reg[15:0], 4'h0};
                  dat_reg <= pwdata[1] ? div_word_reg[19] : ref_word_reg[15];
                  bits_reg <= pwdata[1] ? 5'(`SPD_DIV_WORD_BITS) : 5'(`SPD_REF_WORD_BITS);
                  state_reg <= spd_pkg::SPD_SHIFT;
               end
            end
            spd_pkg::SPD_SHIFT: begin
               // Data moves on the fall, so it is settled a half period before each rise
               if (half_done) begin
                  if (!sck_reg) begin
                     sck_reg <= bits_reg != 5'h0_0 ? 1'b1 : 1'b0;
                     if (bits_reg == 5'h0_0) begin
                        state_reg <= spd_pkg::SPD_LOAD;
                        le_reg <= 1'b1;
                     end
                  end else begin
                     sck_reg <= 1'b0;
                     dat_reg <= word_reg[18];
                     word_reg <= {word_reg[18:0], 1'b0};
                     bits_reg <= bits_reg - 5'h0_1;
                  end
               end
            end
            spd_pkg::SPD_LOAD: begin
               if (half_done) begin
                  le_reg <= 1'b0;
                  state_reg <= spd_pkg::SPD_DONE;
               end
            end
            spd_pkg::SPD_DONE: begin
               done_reg <= 1'b1;
               state_reg <= spd_pkg::SPD_IDLE;
            end
            default: state_reg <= spd_pkg::SPD_IDLE;
         endcase
      end
   end
   assign link.serial_data = dat_reg;
   assign link.shift_clk = sck_reg;
   assign link.latch_load_strobe = le_reg;
   assign link.phase_polarity_select = pol_reg;
endmodule
`default_nettype wire

/* verif/spd_link_sva.sv */
// Purpose: Link timing and drive-pin checks for the synthesizer pair
// Assumes: Host HALF of 4 pclk; single pclk domain
// Notes: Sits beside the link interface, no bind
`timescale 1ns/10ps
`default_nettype none
module spd_link_sva (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Link
   input wire logic serial_data,
   input wire logic shift_clk,
   input wire logic latch_load_strobe,
   // Synthesizer drives
   input wire logic pump_out,
   input wire logic pump_oe,
   input wire logic r_drive,
   input wire logic p_drive_out,
   input wire logic p_drive_oe,
   input wire logic fast_lock_switch_out,
   input wire logic fast_lock_switch_oe,
   input wire logic lock_indicator
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   // Pulse shapes of the host's shift clock and strobe
   sequence s_sck_pulse;
      shift_clk [*4] ##1 !shift_clk;
   endsequence
   sequence s_strobe_pulse;
      latch_load_strobe [*4] ##1 !latch_load_strobe;
   endsequence
   chk_sck_width: assert property ($rose(shift_clk) |-> s_sck_pulse)
      else $error("shift clock high time wrong");
   chk_data_hold: assert property (shift_clk && $past(shift_clk) |-> $stable(serial_data))
      else $error("serial data moved while shift clock high");
   chk_strobe_width: assert property ($rose(latch_load_strobe) |-> s_strobe_pulse)
      else $error("strobe high time wrong");
   chk_strobe_quiet: assert property (latch_load_strobe |-> !shift_clk)
      else $error("shift clock toggled during strobe");
   chk_r_drive_table: assert property (r_drive == (pump_oe && !pump_out))
      else $error("R drive disagrees with pump");
   chk_p_drive_table: assert property (p_drive_oe == (pump_oe && pump_out))
      else $error("P drive disagrees with pump");
   chk_p_open_drain: assert property (p_drive_oe |-> !p_drive_out)
      else $error("P drive pulled high");
   // Sync delay allowed before the switch follows the strobe
   chk_switch_open: assert property (!latch_load_strobe [*5] |-> !fast_lock_switch_oe)
      else $error("switch driven with strobe low");
   chk_switch_close: assert property (latch_load_strobe [*4] ##0 pump_oe |->
      fast_lock_switch_oe && fast_lock_switch_out == pump_out)
      else $error("switch not passing pump");
   chk_lock_pump: assert property (!lock_indicator |-> pump_oe)
      else $error("lock low with pump idle");
endmodule
`default_nettype wire

/* verif/serial_pll_divider_control_bench.sv */
// Purpose: Self-checking bench for host and synthesizer ends
// Assumes: HALF 4, clk_en held high, oscillators made from pclk
// Notes: Monitor periods check the divider chains
`timescale 1ns/10ps
`default_nettype none
`include "spd_regs.svh"
module serial_pll_divider_control_bench;
   typedef struct packed {
      logic dv;
      logic [13:0] a;
      logic [7:0] b;
   } spd_row_t;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata;
   logic pready, pslverr, pump_out, pump_oe, r_drive, p_drive_out, p_drive_oe;
   logic fast_lock_switch_out, fast_lock_switch_oe, compare_monitor, lock_indicator, prescaler_ratio_select;
   logic ref_osc_input = 1'b0;
   logic vco_input = 1'b0;
   logic pol = 1'b1;
   logic [13:0] ref_count;
   logic [10:0] main_count;
   logic [7:0] swallow_count;
   logic [19:0] shifted = 20'h0_0000;
   int miscompares = 0;
   int checked = 0;
   int n_shift = 0;
   int n_ref = 0;
   int n_vco = 0;
   int ph = 0;
   // Reference rows: a count, b[0] ratio; divider rows: a main, b swallow
   // rows keep legal counts
   spd_row_t rows [8] = '{'{1'b0, 14'h0008, 8'h01}, '{1'b0, 14'h3fff, 8'h00}, '{1'b0, 14'h1555, 8'h01},
      '{1'b1, 14'h0010, 8'h00}, '{1'b1, 14'h07ff, 8'hff}, '{1'b1, 14'h02aa, 8'h55},
      '{1'b1, 14'h0010, 8'h03}, '{1'b0, 14'h0009, 8'h01}};
   spd_link_if lnk ();
   spd_host i_spd_host (.pclk(pclk), .presetn(presetn), .clk_en(1'b1), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .link(lnk));
   spd_synth i_spd_synth (.pclk(pclk), .presetn(presetn), .clk_en(1'b1), .link(lnk),
      .ref_osc_input(ref_osc_input), .vco_input(vco_input), .pump_out(pump_out), .pump_oe(pump_oe),
      .r_drive(r_drive), .p_drive_out(p_drive_out), .p_drive_oe(p_drive_oe),
      .fast_lock_switch_out(fast_lock_switch_out), .fast_lock_switch_oe(fast_lock_switch_oe),
      .compare_monitor(compare_monitor), .lock_indicator(lock_indicator), .ref_count(ref_count),
      .prescaler_ratio_select(prescaler_ratio_select), .main_count(main_count), .swallow_count(swallow_count));
   spd_link_sva i_spd_link_sva (.pclk(pclk), .presetn(presetn), .serial_data(lnk.serial_data),
      .shift_clk(lnk.shift_clk), .latch_load_strobe(lnk.latch_load_strobe), .pump_out(pump_out),
      .pump_oe(pump_oe), .r_drive(r_drive), .p_drive_out(p_drive_out), .p_drive_oe(p_drive_oe),
      .fast_lock_switch_out(fast_lock_switch_out), .fast_lock_switch_oe(fast_lock_switch_oe),
      .lock_indicator(lock_indicator));
   // Clock
   initial begin
      forever #10 pclk = ~pclk;
   end
   // Oscillators at 6 and 8 pclk, different so the pump works
   always @(posedge pclk) begin
      ph <= ph + 1;
      if (ph % 3 == 2) ref_osc_input <= ~ref_osc_input;
      if (ph % 4 == 3) vco_input <= ~vco_input;
   end
   // Edge counts and captured link bits
   always @(posedge ref_osc_input) n_ref <= n_ref + 1;
   always @(posedge vco_input) n_vco <= n_vco + 1;
   always @(posedge lnk.shift_clk) begin
      shifted <= {shifted[18:0], lnk.serial_data};
      n_shift <= n_shift + 1;
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic stop_test();
      $display("Comparisons %0d, mismatches %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task automatic give_up();
      miscompares++;
      $display("CHECK FAILED at %0t: wait ran out", $time);
      stop_test();
   endtask
   // One APB transfer; read data and error taken at the pready edge
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
      output logic [31:0] rd, output logic err);
      int n;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) give_up();
      err = pslverr;
      rd = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   // Load a word, start the shift, poll the sticky done bit
   task automatic send(input logic dv, input logic [19:0] w);
      logic [31:0] rd;
      logic err;
      int n;
      int s;
      apb(1'b1, dv ? `SPD_REG_DIVW : `SPD_REG_REFW, {12'h000, w}, rd, err);
      s = n_shift;
      apb(1'b1, `SPD_REG_CTRL, {23'h00_0000, 1'b1, 6'h00, dv, pol}, rd, err);
      n = 0;
      do begin
         apb(1'b0, `SPD_REG_STAT, 32'h0000_0000, rd, err);
         n++;
      end while (rd[1] !== 1'b1 && n < 200);
      if (n >= 200) give_up();
      repeat (4) @(posedge pclk);
      check(n_shift - s, dv ? 20 : 16);
      check(shifted & (dv ? 20'hf_ffff : 20'h0_ffff), w);
   endtask
   task automatic wait_mon();
      int n;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (compare_monitor !== 1'b1 && n < 20000);
      if (n >= 20000) give_up();
   endtask
   // Input edges between two monitor pulses
   task automatic measure(input logic vco, input int exp);
      int s;
      wait_mon();
      s = vco ? n_vco : n_ref;
      @(posedge pclk);
      wait_mon();
      check(vco ? n_vco - s : n_ref - s, exp);
   endtask
   initial begin
      logic [31:0] rd;
      logic err;
      logic [13:0] e_ref;
      logic e_rat;
      logic [10:0] e_main;
      logic [7:0] e_swl;
      e_ref = 14'h0008;
      e_rat = 1'b1;
      e_main = 11'h010;
      e_swl = 8'h00;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      // Rows: each load must touch only the selected latch
      foreach (rows[i]) begin
         if (rows[i].dv) begin
            e_main = rows[i].a[10:0];
            e_swl = rows[i].b;
            send(1'b1, {rows[i].a[10:0], rows[i].b, 1'b0});
         end else begin
            e_ref = rows[i].a;
            e_rat = rows[i].b[0];
            send(1'b0, {4'h0, rows[i].b[0], rows[i].a, 1'b1});
         end
         check({ref_count, prescaler_ratio_select}, {e_ref, e_rat});
         check({main_count, swallow_count}, {e_main, e_swl});
      end
      check({lnk.latch_load_strobe, lnk.shift_clk, fast_lock_switch_oe}, 3'b000);
      apb(1'b1, 12'h010, 32'h0000_0001, rd, err);
      check(err, 1'b1);
      apb(1'b0, `SPD_REG_DIVW, 32'h0000_0000, rd, err);
      check(rd, 32'h0000_2006);
      // Monitor: reference side 9, then VCO side 128 x 16 + 3
      measure(1'b0, 9);
      pol = 1'b0;
      apb(1'b1, `SPD_REG_CTRL, {31'h0000_0000, pol}, rd, err);
      repeat (4) @(posedge pclk);
      measure(1'b1, 2051);
      // Mid-run reset returns latches and pins to idle values
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      check({ref_count, prescaler_ratio_select, main_count}, {`SPD_REF_RST, 1'b1, `SPD_MAIN_RST});
      check({swallow_count, lock_indicator, fast_lock_switch_oe}, {`SPD_SWAL_RST, 1'b1, 1'b0});
      presetn <= 1'b1;
      repeat (2) @(posedge pclk);
      stop_test();
   end
endmodule
`default_nettype wire
